// ### shared/qdac_params.svh
// constants for the quad dac serial control block
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH
`define QDAC_WORD_BITS   16
`define QDAC_DATA_BITS   12
`define QDAC_CODE_MSB    15
`define QDAC_CODE_LSB    12
`define QDAC_DATA_RESET  12'h000
`define QDAC_CODE_NOP    4'h0
`define QDAC_CODE_UPO_LO 4'h2
`define QDAC_CODE_UPDATE 4'h4
`define QDAC_CODE_UPO_HI 4'h6
`define QDAC_CODE_LDALL  4'h8
`define QDAC_CODE_MODE0  4'ha
`define QDAC_CODE_SHDN   4'hc
`define QDAC_CODE_MODE1  4'he
`define QDAC_CTRL_LOAD   2'h1
`define QDAC_CTRL_LDUPD  2'h3
`define QDAC_SCLK_MAX_HZ 10000000
`define QDAC_CLK_HZ      50000000
`endif

// ### shared/qdac_pkg.sv
// types for the quad dac serial control block
package qdac_pkg;
  typedef logic [11:0] qdac_data_t;
  typedef struct packed {
    logic [1:0] addr_bits;
    logic [1:0] ctrl_bits;
    logic [11:0] data_bits;
  } qdac_word_s;
  typedef struct packed {
    qdac_data_t dac_d;
    qdac_data_t dac_c;
    qdac_data_t dac_b;
    qdac_data_t dac_a;
  } qdac_dacs_s;
endpackage : qdac_pkg

// ### rtl/qdac_sync.sv
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ns
module qdac_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] hold_reg;
  // flops keep the pin xor its idle level, so reset shows the idle level
  // and no false edge follows the release of reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      hold_reg <= '0;
    end else begin
      meta_reg <= async_in ^ reset_val_in;
      hold_reg <= meta_reg;
    end
  end
  assign sync_out = hold_reg ^ reset_val_in;
endmodule : qdac_sync

// ### rtl/qdac_ctrl.sv
// serial control logic of a quad 12-bit dac
`timescale 1ns/1ns
`include "qdac_params.svh"
module qdac_ctrl
  import qdac_pkg::*;
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  // serial link pins
  input  wire logic chip_select_n_in,
  input  wire logic serial_clock_in,
  input  wire logic serial_in,
  output logic      serial_out,
  // control pins
  input  wire logic clear_n_in,
  input  wire logic shutdown_lockout_n_in,
  // outputs to analog section
  output qdac_dacs_s dac_regs_out,
  output qdac_dacs_s input_regs_out,
  output logic       user_output_out,
  output logic       shutdown_out,
  output logic       mode1_out
);
  logic rst_meta_reg;
  logic rst_n_reg;
  logic [3:0] pins_sync;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic clr_n_s;
  logic pdl_n_s;
  logic cs_n_prev_reg;
  logic sclk_prev_reg;
  logic pdl_n_prev_reg;
  logic [`QDAC_WORD_BITS-1:0] shift_reg;
  logic [`QDAC_WORD_BITS-1:0] shift_next;
  logic       out_reg;
  logic       eject_reg;
  logic       pdl_n_async;
  logic       mode1_reg;
  logic       upo_reg;
  logic       shdn_reg;
  qdac_data_t in_reg  [4];
  qdac_data_t dac_reg [4];

  // reset release through two flip-flops
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  qdac_sync #(.WIDTH(5)) u_sync (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_reg),
    .async_in     ({pdl_n_async, clear_n_in, serial_in, serial_clock_in,
                    chip_select_n_in}),
    .reset_val_in (5'h19),
    .sync_out     ({pdl_n_s, clr_n_s, din_s, sclk_s, cs_n_s})
  );
  assign pdl_n_async = shutdown_lockout_n_in;

  // edge detection on synchronised pins
  wire sclk_rise = sclk_s & ~sclk_prev_reg;
  wire sclk_fall = ~sclk_s & sclk_prev_reg;
  wire cs_rise   = cs_n_s & ~cs_n_prev_reg;
  wire pdl_fall  = ~pdl_n_s & pdl_n_prev_reg;
  wire shift_en  = ~cs_n_s & sclk_rise;

  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sclk_prev_reg  <= 1'b0;
      cs_n_prev_reg  <= 1'b1;
      pdl_n_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg  <= sclk_s;
      cs_n_prev_reg  <= cs_n_s;
      pdl_n_prev_reg <= pdl_n_s;
    end
  end

  // command decode of the whole captured word
  qdac_word_s word;
  assign word = qdac_word_s'(shift_reg);
  wire [3:0] code = {word.addr_bits, word.ctrl_bits};
  wire exec     = cs_rise;
  wire ld_one   = exec & (word.ctrl_bits == `QDAC_CTRL_LOAD ||
                          word.ctrl_bits == `QDAC_CTRL_LDUPD);
  wire upd_all  = exec & (word.ctrl_bits == `QDAC_CTRL_LDUPD ||
                          code == `QDAC_CODE_UPDATE ||
                          code == `QDAC_CODE_MODE0 ||
                          code == `QDAC_CODE_MODE1);
  wire ld_all   = exec & (code == `QDAC_CODE_LDALL);
  wire shdn_cmd = exec & (code == `QDAC_CODE_SHDN) & pdl_n_s;
  wire wake     = upd_all | ld_all | pdl_fall;

  // msb first: new bit enters at the bottom
  assign shift_next = {shift_reg[`QDAC_WORD_BITS-2:0], din_s};

  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shift_reg <= '0;
      eject_reg <= 1'b0;
    end else if (!clr_n_s) begin
      shift_reg <= '0;
      eject_reg <= 1'b0;
    end else if (shift_en) begin
      shift_reg <= shift_next;
      eject_reg <= shift_reg[`QDAC_WORD_BITS-1];
    end
  end

  // mode 0 shifts out on falling clock, mode 1 on rising
  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      out_reg <= 1'b0;
    end else if (!clr_n_s) begin
      out_reg <= 1'b0;
    end else if (!cs_n_s && mode1_reg && sclk_rise) begin
      // mode 1 presents the bit this rising edge pushes out
      out_reg <= shift_reg[`QDAC_WORD_BITS-1];
    end else if (!cs_n_s && !mode1_reg && sclk_fall) begin
      // mode 0 trails by half a clock: the bit ejected at the last rise
      out_reg <= eject_reg;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode1_reg <= 1'b0;
      upo_reg   <= 1'b0;
      shdn_reg  <= 1'b0;
    end else if (!clr_n_s) begin
      mode1_reg <= 1'b0;
      upo_reg   <= 1'b0;
      shdn_reg  <= 1'b0;
    end else begin
      if (exec && code == `QDAC_CODE_MODE1) begin
        mode1_reg <= 1'b1;
      end else if (exec && code == `QDAC_CODE_MODE0) begin
        mode1_reg <= 1'b0;
      end
      if (exec && code == `QDAC_CODE_UPO_HI) begin
        upo_reg <= 1'b1;
      end else if (exec && code == `QDAC_CODE_UPO_LO) begin
        upo_reg <= 1'b0;
      end
      if (wake) begin
        shdn_reg <= 1'b0;
      end else if (shdn_cmd) begin
        shdn_reg <= 1'b1;
      end
    end
  end

  // input and dac registers; nop and other codes fall through
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      wire sel = ld_one & (word.addr_bits == 2'(g));
      qdac_data_t in_next;
      assign in_next = (ld_all | sel) ? word.data_bits : in_reg[g];
      always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          in_reg[g]  <= `QDAC_DATA_RESET;
          dac_reg[g] <= `QDAC_DATA_RESET;
        end else if (!clr_n_s) begin
          in_reg[g]  <= `QDAC_DATA_RESET;
          dac_reg[g] <= `QDAC_DATA_RESET;
        end else begin
          in_reg[g] <= in_next;
          if (ld_all | upd_all) begin
            dac_reg[g] <= in_next;
          end
        end
      end
    end
  endgenerate

  assign serial_out      = out_reg;
  assign user_output_out = upo_reg;
  assign shutdown_out    = shdn_reg;
  assign mode1_out       = mode1_reg;
  assign dac_regs_out    = '{dac_reg[3], dac_reg[2], dac_reg[1], dac_reg[0]};
  assign input_regs_out  = '{in_reg[3], in_reg[2], in_reg[1], in_reg[0]};
endmodule : qdac_ctrl

// ### test/qdac_ctrl_sva.sv
// assertion checker for qdac_ctrl
`timescale 1ns/1ns
module qdac_ctrl_sva
  import qdac_pkg::*;
(
  // clock and reset
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  // pins
  input wire logic       chip_select_n_in,
  input wire logic       clear_n_in,
  input wire logic       shutdown_lockout_n_in,
  input wire logic       serial_out,
  // state
  input wire qdac_dacs_s dac_regs_out,
  input wire qdac_dacs_s input_regs_out,
  input wire logic       user_output_out,
  input wire logic       shutdown_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_idle; (chip_select_n_in && clear_n_in)[*8]; endsequence
  sequence s_busy; (!chip_select_n_in && clear_n_in)[*8]; endsequence
  property p_idle; s_idle |=> $stable(input_regs_out); endproperty
  property p_out; s_idle |=> $stable(serial_out); endproperty
  property p_busy; s_busy |=> $stable(dac_regs_out); endproperty
  property p_clr; (!clear_n_in)[*5] |-> input_regs_out == 48'h0
    && dac_regs_out == 48'h0 && !user_output_out && !serial_out;
  endproperty
  property p_lock;
    $rose(shutdown_out) |-> $past(shutdown_lockout_n_in, 3);
  endproperty
  property p_wake; shutdown_out && $fell(shutdown_lockout_n_in)
    |-> ##[1:6] !shutdown_out; endproperty
  property p_upd; $changed(dac_regs_out)
    |-> dac_regs_out == input_regs_out && !shutdown_out; endproperty
  property p_upo; $changed(user_output_out) && clear_n_in
    |-> $stable(dac_regs_out) && $stable(input_regs_out); endproperty
  a_idle: assert property (p_idle) else $error("idle load");
  a_out: assert property (p_out) else $error("idle shift");
  a_busy: assert property (p_busy) else $error("early exec");
  a_clr: assert property (p_clr) else $error("clear");
  a_lock: assert property (p_lock) else $error("lockout");
  a_wake: assert property (p_wake) else $error("no wake");
  a_upd: assert property (p_upd) else $error("bad update");
  a_upo: assert property (p_upo) else $error("upo side");
endmodule : qdac_ctrl_sva
bind qdac_ctrl qdac_ctrl_sva u_sva (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .chip_select_n_in(chip_select_n_in),
  .clear_n_in(clear_n_in), .serial_out(serial_out),
  .shutdown_lockout_n_in(shutdown_lockout_n_in),
  .dac_regs_out(dac_regs_out), .input_regs_out(input_regs_out),
  .user_output_out(user_output_out), .shutdown_out(shutdown_out));

// ### test/qdac_host.sv
// host model that masters the serial link
`timescale 1ns/1ns
module qdac_host (
  // clock and echo
  input  wire logic  clock_in,
  input  wire logic  serial_out,
  // link pins
  output logic       chip_select_n_out,
  output logic       serial_clock_out,
  output logic       serial_in_out
);
  logic [31:0] echo = 32'h0;
  initial begin
    chip_select_n_out = 1'b1;
    serial_clock_out  = 1'b0;
    serial_in_out     = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock_in);
  endtask : hold
  // sel low toggles the clock with select high; 4 clocks a level = 80 ns, 12 clocks for the low level of bit 7
  task automatic send(input logic [31:0] w, input int n, input logic sel);
    chip_select_n_out <= ~sel;
    hold(4);
    for (int i = n - 1; i >= 0; i--) begin
      echo             <= {echo[30:0], serial_out};
      serial_clock_out <= 1'b0;
      serial_in_out    <= w[i];
      hold(i == 7 ? 12 : 4);
      serial_clock_out <= 1'b1;
      hold(4);
    end
    echo              <= {echo[30:0], serial_out};
    serial_clock_out  <= 1'b0;
    hold(4);
    // a released line must not keep showing the last bit
    serial_in_out     <= ~serial_in_out;
    chip_select_n_out <= 1'b1;
    hold(12);
  endtask : send
endmodule : qdac_host

// ### test/quad_dac_serial_control_bench.sv
// self-checking bench for the quad dac serial control
`timescale 1ns/1ns
module quad_dac_serial_control_bench;
  import qdac_pkg::*;
  logic        clock_in, rst_n_in, clear_n_in, lock_n;
  logic        cs_n, sclk, sdi, sdo, user_output, sd, m1, upo_m, sd_m, m1_m;
  qdac_dacs_s  dacs, ins;
  logic [11:0] in_m[4], dac_m[4];
  logic [15:0] w, a;
  int          n_errors = 0, checked = 0, seed = 32'h5f60;
  qdac_ctrl u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .chip_select_n_in(cs_n), .serial_clock_in(sclk), .serial_in(sdi),
    .serial_out(sdo), .clear_n_in(clear_n_in),
    .shutdown_lockout_n_in(lock_n), .dac_regs_out(dacs),
    .input_regs_out(ins), .user_output_out(user_output), .shutdown_out(sd),
    .mode1_out(m1));
  qdac_host u_host (.clock_in(clock_in), .serial_out(sdo),
    .chip_select_n_out(cs_n), .serial_clock_out(sclk),
    .serial_in_out(sdi));
  task automatic chk(input string nm, input logic [47:0] e, s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic cmp();
    chk("dac", {dac_m[3], dac_m[2], dac_m[1], dac_m[0]}, dacs);
    chk("input", {in_m[3], in_m[2], in_m[1], in_m[0]}, ins);
    chk("flags", 48'({upo_m, sd_m, m1_m}), 48'({user_output, sd, m1}));
  endtask : cmp
  task automatic zero();
    in_m = '{4{12'h000}};
    dac_m = in_m;
    {upo_m, sd_m, m1_m} = 3'h0;
  endtask : zero
  task automatic run(input logic [31:0] f, input int n);
    logic [3:0] k;
    u_host.send(f, n, 1'b1);
    k = w[15:12];
    if (k[0]) in_m[k[3:2]] = w[11:0];
    if (k == 4'h8) in_m = '{4{w[11:0]}};
    if (k[1:0] == 2'h3 || k == 4'h4 || k == 4'h8 || k[3:1] == 3'h5
        || k == 4'he) begin
      dac_m = in_m;
      sd_m  = 1'b0;
    end
    if (k == 4'hc && lock_n) sd_m = 1'b1;
    if (k == 4'h2 || k == 4'h6) upo_m = k[2];
    if (k == 4'ha || k == 4'he) m1_m = k[2];
    cmp();
  endtask : run
  task automatic finish_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    repeat (40000) @(posedge clock_in);
    n_errors++;
    finish_test();
  end
  initial begin
    {rst_n_in, clear_n_in, lock_n} = 3'h2;
    zero();
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    cmp();
    // first two passes hold lockout low so shutdown is refused
    for (int i = 0; i < 48; i++) begin
      lock_n <= (i > 31);
      w = {4'(i), 12'($random(seed))};
      run({16'h0, w}, 16);
    end
    w = 16'hc000;
    run({16'h0, w}, 16);
    lock_n <= 1'b0;
    repeat (8) @(posedge clock_in);
    sd_m = 1'b0;
    cmp();
    w = 16'ha000;
    run({16'h0, w}, 16);
    w = 16'he000;
    run({16'h0, w}, 16);
    a = 16'($random(seed));
    w = {4'h1, 12'($random(seed))};
    run({a, w}, 32);
    chk("echo", 48'(a), 48'(u_host.echo[15:0]));
    u_host.send(32'($random(seed)), 16, 1'b0);
    w = {w[7:0], 8'h5a};
    run(32'h5a, 8);
    clear_n_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    zero();
    cmp();
    finish_test();
  end
endmodule : quad_dac_serial_control_bench
